/* core/adc_ctrl_pkg.sv */
// Shared constants, types and helper functions for the converter control
// block. Assumes a single base clock and byte addresses on the register bus.
package adc_ctrl_pkg;

  // ----------------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [4:0] OFS_IRQ_CTRL = 5'h00;
  localparam logic [4:0] OFS_SAMPLE_A = 5'h04;
  localparam logic [4:0] OFS_SAMPLE_B = 5'h08;
  localparam logic [4:0] OFS_SAMPLE_SEL = 5'h0c;
  localparam logic [4:0] OFS_COMPARE_TIME = 5'h10;
  localparam logic [4:0] OFS_THRESHOLD = 5'h14;
  localparam logic [4:0] OFS_STATUS = 5'h18;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int BIT_SCAN_FLAG = 15;
  localparam int BIT_PRIO_FLAG = 14;
  localparam int BIT_CMP_FLAG = 13;
  localparam int BIT_RESERVED = 12;
  localparam int BIT_SCAN_EN = 11;
  localparam int BIT_PRIO_EN = 10;
  localparam int BIT_CMP_EN = 9;
  localparam int BIT_OVR_EN = 8;
  localparam int POS_MULT = 8;
  localparam int POS_PRIO_THR = 8;
  localparam int BIT_CMP_FUNC_EN = 16;

  // ----------------------------------------------------------------------
  // Reset values and timing constants
  // ----------------------------------------------------------------------
  localparam logic [4:0] RST_SAMPLE_COUNT = 5'h00;
  localparam logic [2:0] RST_MULT = 3'h0;
  localparam logic [7:0] RST_COMPARE_DIV = 8'h00;
  localparam logic [3:0] RST_SCAN_THR = 4'h0;
  localparam logic [1:0] RST_PRIO_THR = 2'h0;
  localparam logic [2:0] MULT_X1 = 3'h0;
  localparam logic [2:0] MULT_X4 = 3'h1;
  localparam logic [11:0] COMPARE_CLOCKS = 12'h00e;
  localparam logic [11:0] DIV_OFFSET = 12'h002;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_SAMPLE = 2'b01,
    PH_COMPARE = 2'b10
  } phase_t;

  // Sampling phase length in base cycles: (count + 1) * multiplier + 1.
  // Codes other than the x4 code act as x1.
  function automatic logic [11:0] sample_cycles(input logic [4:0] count,
                                                input logic [2:0] mult);
    logic [11:0] base;
    base = {7'h00, count} + 12'h001;
    if (mult == MULT_X4) begin
      base = {base[9:0], 2'b00};
    end
    return base + 12'h001;
  endfunction : sample_cycles

  // Comparison phase length: 14 compare clocks of (field + 2) base cycles.
  function automatic logic [11:0] compare_cycles(input logic [7:0] div);
    logic [11:0] ratio;
    ratio = {4'h0, div} + DIV_OFFSET;
    return ratio * COMPARE_CLOCKS;
  endfunction : compare_cycles

endpackage : adc_ctrl_pkg

/* core/conv_timer.sv */
// Conversion phase timer: one sampling phase followed by one comparison
// phase per channel conversion. Assumes start is a one-cycle pulse from
// logic on the same clock; the settings are sampled only at start.
`timescale 1ns/100ps
module conv_timer
  import adc_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic start,
  input wire logic [4:0] sampleCount,
  input wire logic [2:0] multSel,
  input wire logic [7:0] divSel,
  output logic sampling,
  output logic comparing,
  output logic convDone
);

  // ----------------------------------------------------------------------
  // Phase state and down-counter
  // ----------------------------------------------------------------------
  phase_t phaseReg, phaseNext;
  logic [11:0] cntReg, cntNext;
  logic [11:0] cmpLenReg, cmpLenNext;
  logic doneNext;

  // A new start restarts the conversion even mid-phase, like a re-trigger.
  always_comb begin
    phaseNext = phaseReg;
    cntNext = cntReg;
    cmpLenNext = cmpLenReg;
    doneNext = 1'b0;
    if (start) begin
      phaseNext = PH_SAMPLE;
      cntNext = sample_cycles(sampleCount, multSel) - 12'h001; // [RULE3] [RULE23]
      cmpLenNext = compare_cycles(divSel); // [RULE7] [RULE8]
    end else begin
      unique case (phaseReg)
        PH_IDLE: begin
          phaseNext = PH_IDLE;
        end
        PH_SAMPLE: begin
          if (cntReg == 12'h000) begin
            phaseNext = PH_COMPARE; // [RULE1]
            cntNext = cmpLenReg - 12'h001;
          end else begin
            cntNext = cntReg - 12'h001;
          end
        end
        PH_COMPARE: begin
          if (cntReg == 12'h000) begin
            phaseNext = PH_IDLE;
            doneNext = 1'b1;
          end else begin
            cntNext = cntReg - 12'h001;
          end
        end
        default: begin
          phaseNext = PH_IDLE;
        end
      endcase
    end
  end

  // Outputs are registered from the next phase so they track phaseReg.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      phaseReg <= PH_IDLE;
      cntReg <= 12'h000;
      cmpLenReg <= 12'h000;
      sampling <= 1'b0;
      comparing <= 1'b0;
      convDone <= 1'b0;
    end else begin
      phaseReg <= phaseNext;
      cntReg <= cntNext;
      cmpLenReg <= cmpLenNext;
      sampling <= (phaseNext == PH_SAMPLE);
      comparing <= (phaseNext == PH_COMPARE);
      convDone <= doneNext;
    end
  end

  // ----------------------------------------------------------------------
  // Checks on phase order and lengths
  // ----------------------------------------------------------------------
  logic [11:0] phaseCycles;
  logic [11:0] sampLenReg;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      phaseCycles <= 12'h000;
      sampLenReg <= 12'h000;
    end else begin
      phaseCycles <= (start || phaseNext != phaseReg) ? 12'h000
                     : phaseCycles + 12'h001;
      if (start) begin
        sampLenReg <= sample_cycles(sampleCount, multSel);
      end
    end
  end

  sequence samp_end;
    phaseReg == PH_SAMPLE && cntReg == 12'h000 && !start;
  endsequence
  sequence cmp_end;
    phaseReg == PH_COMPARE && cntReg == 12'h000 && !start;
  endsequence

  a_sample_len: assert property (@(posedge clk) disable iff (!reset_n) // [RULE3]
    samp_end |-> phaseCycles + 12'h001 == sampLenReg)
    else $error("sampling phase length wrong");
  a_conv_order: assert property (@(posedge clk) disable iff (!reset_n) // [RULE1]
    samp_end |=> comparing && !sampling && phaseCycles == 12'h000)
    else $error("comparison did not follow sampling");
  a_compare_len: assert property (@(posedge clk) disable iff (!reset_n) // [RULE7]
    cmp_end |-> phaseCycles + 12'h001 == cmpLenReg ##1 convDone)
    else $error("comparison phase length wrong");
  a_div_zero: assert property (@(posedge clk) disable iff (!reset_n) // [RULE8]
    start && divSel == 8'h00 |=> cmpLenReg == 12'h01c)
    else $error("zero divider not ratio two");

endmodule : conv_timer

/* core/adc_timing_and_irq_flags.sv */
// Converter control: conversion timing and the interrupt flag/enable
// register, reached over an Avalon-MM slave with waitrequest.
// Assumes FIFO, comparator and arbitration logic on the same clock
// report their events as one-cycle pulses and levels.
//
// Behaviour
// (RULE1) A conversion is a sampling phase then a comparison phase.
// (RULE2) Two sampling settings; a per-channel select bit picks one.
// (RULE3) Sampling lasts (count + 1) times multiplier, plus one, cycles.
// (RULE4) Multiplier code 000 means times one, 001 means times four.
// (RULE5) Software keeps count at least 4 (3 on reduced parts) with x1.
// (RULE6) Software keeps count at least 1 with x4, never zero.
// (RULE7) Comparison lasts 14 compare clocks of ratio base cycles each.
// (RULE8) Compare division field zero gives a ratio of two.
// (RULE9) Scan-done flag bit15 sets when scan FIFO reaches threshold.
// (RULE10) Priority-done flag bit14 sets when priority FIFO reaches threshold.
// (RULE11) Compare-match flag bit13 sets on a hit while comparison enabled.
// (RULE12) Writing 0 clears a flag, writing 1 leaves it; reads show it.
// (RULE13) Read-modify-write reads return 1 for every event flag.
// (RULE14) Scan enable bit11 with scan flag raises an interrupt.
// (RULE15) Reserved bit12 ignores writes; reads are unspecified.
// (RULE16) Software programs enable period then polls the enable state.
// (RULE17) Software flushes, selects single mode, then starts the scan.
// (RULE18) Software reads low half first, upper half only if valid.
// (RULE19) Priority enable with priority flag raises an interrupt.
// (RULE20) Compare enable with compare flag raises an interrupt.
// (RULE21) Overrun enable with either overrun flag raises an interrupt.
// (RULE22) Each request is a level equal to flag AND enable.
// (RULE23) Phases are counted by down-counters loaded at conversion start.
`timescale 1ns/100ps
module adc_timing_and_irq_flags
  import adc_ctrl_pkg::*;
#(
  parameter int NUM_CH = 32
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic rmwRead,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic convStart,
  input wire logic [4:0] convChannel,
  input wire logic scanWrite,
  input wire logic [4:0] scanLevel,
  input wire logic prioWrite,
  input wire logic [2:0] prioLevel,
  input wire logic compareHit,
  input wire logic scanOverrun,
  input wire logic prioOverrun,
  output logic sampling,
  output logic comparing,
  output logic convDone,
  output logic compareFuncEn,
  output logic scanIrq,
  output logic prioIrq,
  output logic compareIrq,
  output logic overrunIrq
);

  if (NUM_CH < 1 || NUM_CH > 32) begin : g_bad_ch
    $error("NUM_CH must lie between 1 and 32");
  end

  // ----------------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------------
  // Every access answers one cycle after it appears; writes land at the
  // edge where the master sees waitrequest low, never earlier.
  logic waitReg, waitNext;
  logic [31:0] readdataReg, readdataNext;
  logic accept, rdAccept, wrCommit;
  logic [31:0] readValue;

  assign accept = (read || write) && waitReg;
  assign rdAccept = accept && read;
  assign wrCommit = write && !waitReg;

  // Byte-lane merge of a write into a stored 32-bit word.
  function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                             input logic [31:0] data,
                                             input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res;
  endfunction : lane_merge

  // ----------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------
  logic [4:0] countAReg, countANext, countBReg, countBNext;
  logic [2:0] multAReg, multANext, multBReg, multBNext;
  logic [31:0] selectReg, selectNext;
  logic [7:0] divReg, divNext;
  logic [3:0] scanThrReg, scanThrNext;
  logic [1:0] prioThrReg, prioThrNext;
  logic cmpFuncReg, cmpFuncNext;
  logic [31:0] chMask, wordA, wordB, wordThr;

  assign chMask = (NUM_CH == 32) ? 32'hffffffff
                  : ((32'h00000001 << NUM_CH) - 32'h00000001);
  assign wordA = {21'h000000, multAReg, 3'h0, countAReg};
  assign wordB = {21'h000000, multBReg, 3'h0, countBReg};
  assign wordThr = {15'h0000, cmpFuncReg, 6'h00, prioThrReg, 4'h0,
                    scanThrReg};

  // Software-written settings, merged per byte lane at the commit edge.
  always_comb begin
    logic [31:0] m;
    m = 32'h00000000;
    countANext = countAReg;
    multANext = multAReg;
    countBNext = countBReg;
    multBNext = multBReg;
    selectNext = selectReg;
    divNext = divReg;
    scanThrNext = scanThrReg;
    prioThrNext = prioThrReg;
    cmpFuncNext = cmpFuncReg;
    if (wrCommit) begin
      unique case (address)
        OFS_SAMPLE_A: begin
          m = lane_merge(wordA, writedata, byteenable);
          countANext = m[4:0];
          multANext = m[POS_MULT +: 3];
        end
        OFS_SAMPLE_B: begin
          m = lane_merge(wordB, writedata, byteenable);
          countBNext = m[4:0];
          multBNext = m[POS_MULT +: 3];
        end
        OFS_SAMPLE_SEL: begin
          selectNext = lane_merge(selectReg, writedata, byteenable) & chMask;
        end
        OFS_COMPARE_TIME: begin
          m = lane_merge({24'h000000, divReg}, writedata, byteenable);
          divNext = m[7:0];
        end
        OFS_THRESHOLD: begin
          m = lane_merge(wordThr, writedata, byteenable);
          scanThrNext = m[3:0];
          prioThrNext = m[POS_PRIO_THR +: 2];
          cmpFuncNext = m[BIT_CMP_FUNC_EN];
        end
        default: begin
          m = 32'h00000000; // Unmapped, flag or status register: nothing here.
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      countAReg <= RST_SAMPLE_COUNT;
      multAReg <= RST_MULT;
      countBReg <= RST_SAMPLE_COUNT;
      multBReg <= RST_MULT;
      selectReg <= 32'h00000000;
      divReg <= RST_COMPARE_DIV;
      scanThrReg <= RST_SCAN_THR;
      prioThrReg <= RST_PRIO_THR;
      cmpFuncReg <= 1'b0;
    end else begin
      countAReg <= countANext;
      multAReg <= multANext;
      countBReg <= countBNext;
      multBReg <= multBNext;
      selectReg <= selectNext;
      divReg <= divNext;
      scanThrReg <= scanThrNext;
      prioThrReg <= prioThrNext;
      cmpFuncReg <= cmpFuncNext;
    end
  end
  assign compareFuncEn = cmpFuncReg;

  // ----------------------------------------------------------------------
  // Conversion timing
  // ----------------------------------------------------------------------
  // The channel's select bit picks setting B, otherwise setting A.
  logic useB;
  assign useB = selectReg[convChannel]; // [RULE2]

  conv_timer u_timer (
    .clk(clk),
    .reset_n(reset_n),
    .start(convStart),
    .sampleCount(useB ? countBReg : countAReg), // [RULE2]
    .multSel(useB ? multBReg : multAReg), // [RULE4]
    .divSel(divReg),
    .sampling(sampling),
    .comparing(comparing),
    .convDone(convDone)
  );

  // ----------------------------------------------------------------------
  // Event flags, enables and interrupt levels
  // ----------------------------------------------------------------------
  logic scanFlagReg, scanFlagNext, prioFlagReg, prioFlagNext;
  logic cmpFlagReg, cmpFlagNext;
  logic [3:0] enReg, enNext;
  logic scanSet, prioSet, cmpSet, flagWrite;

  assign scanSet = scanWrite && (scanLevel == {1'b0, scanThrReg}); // [RULE9]
  assign prioSet = prioWrite && (prioLevel == {1'b0, prioThrReg}); // [RULE10]
  assign cmpSet = compareHit && cmpFuncReg; // [RULE11]
  assign flagWrite = wrCommit && address == OFS_IRQ_CTRL && byteenable[1];

  // A set in the same cycle as a clearing write wins, so no event is lost.
  always_comb begin
    scanFlagNext = scanFlagReg;
    prioFlagNext = prioFlagReg;
    cmpFlagNext = cmpFlagReg;
    enNext = enReg;
    if (flagWrite) begin
      scanFlagNext = scanFlagReg && writedata[BIT_SCAN_FLAG]; // [RULE12]
      prioFlagNext = prioFlagReg && writedata[BIT_PRIO_FLAG]; // [RULE12]
      cmpFlagNext = cmpFlagReg && writedata[BIT_CMP_FLAG]; // [RULE12]
      enNext = writedata[BIT_OVR_EN +: 4]; // Bit 12 is dropped. [RULE15]
    end
    scanFlagNext = scanFlagNext || scanSet;
    prioFlagNext = prioFlagNext || prioSet;
    cmpFlagNext = cmpFlagNext || cmpSet;
  end

  // Requests are registered levels, one cycle behind flag and enable.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      scanFlagReg <= 1'b0;
      prioFlagReg <= 1'b0;
      cmpFlagReg <= 1'b0;
      enReg <= 4'h0;
      scanIrq <= 1'b0;
      prioIrq <= 1'b0;
      compareIrq <= 1'b0;
      overrunIrq <= 1'b0;
    end else begin
      scanFlagReg <= scanFlagNext;
      prioFlagReg <= prioFlagNext;
      cmpFlagReg <= cmpFlagNext;
      enReg <= enNext;
      scanIrq <= scanFlagReg && enReg[3]; // [RULE14] [RULE22]
      prioIrq <= prioFlagReg && enReg[2]; // [RULE19] [RULE22]
      compareIrq <= cmpFlagReg && enReg[1]; // [RULE20] [RULE22]
      overrunIrq <= (scanOverrun || prioOverrun) && enReg[0]; // [RULE21]
    end
  end

  // ----------------------------------------------------------------------
  // Read mux and bus registers
  // ----------------------------------------------------------------------
  // A read-modify-write read shows all flags as one so the write-back of
  // the same word cannot clear a flag that was pending.
  always_comb begin
    readValue = 32'h00000000;
    unique case (address)
      OFS_IRQ_CTRL: begin
        readValue[BIT_SCAN_FLAG] = scanFlagReg || rmwRead; // [RULE13]
        readValue[BIT_PRIO_FLAG] = prioFlagReg || rmwRead; // [RULE13]
        readValue[BIT_CMP_FLAG] = cmpFlagReg || rmwRead; // [RULE13]
        readValue[BIT_OVR_EN +: 4] = enReg;
      end
      OFS_SAMPLE_A: readValue = wordA;
      OFS_SAMPLE_B: readValue = wordB;
      OFS_SAMPLE_SEL: readValue = selectReg;
      OFS_COMPARE_TIME: readValue = {24'h000000, divReg};
      OFS_THRESHOLD: readValue = wordThr;
      OFS_STATUS: readValue = {29'h00000000, convDone, comparing, sampling};
      default: readValue = 32'h00000000;
    endcase
  end

  always_comb begin
    waitNext = !accept;
    readdataNext = rdAccept ? readValue : readdataReg;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      waitReg <= 1'b1;
      readdataReg <= 32'h00000000;
    end else begin
      waitReg <= waitNext;
      readdataReg <= readdataNext;
    end
  end
  assign waitrequest = waitReg;
  assign readdata = readdataReg;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_scan_flag_set: assert property (@(posedge clk) disable iff (!reset_n) // [RULE9]
    scanWrite && scanLevel == {1'b0, scanThrReg} |=> scanFlagReg)
    else $error("scan-done flag not set at threshold");
  a_prio_flag_set: assert property (@(posedge clk) disable iff (!reset_n) // [RULE10]
    prioWrite && prioLevel == {1'b0, prioThrReg} |=> prioFlagReg)
    else $error("priority-done flag not set at threshold");
  a_cmp_flag_gate: assert property (@(posedge clk) disable iff (!reset_n) // [RULE11]
    $rose(cmpFlagReg) |-> $past(compareHit) && $past(cmpFuncReg))
    else $error("compare flag set without enabled hit");
  a_flag_write_clear: assert property (@(posedge clk) disable iff (!reset_n) // [RULE12]
    flagWrite && !writedata[BIT_SCAN_FLAG] && !scanSet |=> !scanFlagReg)
    else $error("writing zero did not clear scan flag");
  a_rmw_read_ones: assert property (@(posedge clk) disable iff (!reset_n) // [RULE13]
    rdAccept && rmwRead && address == OFS_IRQ_CTRL
      |=> !waitrequest && readdata[15:13] == 3'b111)
    else $error("rmw read did not return ones");
  a_scan_irq_level: assert property (@(posedge clk) disable iff (!reset_n) // [RULE14]
    scanFlagReg && enReg[3] |=> scanIrq [*1] ##0 $past(scanFlagReg, 1))
    else $error("scan interrupt missing");
  a_irq_drop: assert property (@(posedge clk) disable iff (!reset_n) // [RULE22]
    !(cmpFlagReg && enReg[1]) |=> !compareIrq)
    else $error("compare interrupt without flag and enable");
  a_overrun_irq: assert property (@(posedge clk) disable iff (!reset_n) // [RULE21]
    (scanOverrun || prioOverrun) && enReg[0] |=> overrunIrq)
    else $error("overrun interrupt missing");

endmodule : adc_timing_and_irq_flags

/* tb/test_adc_timing_and_irq_flags.sv */
// Self-checking bench for the converter control block.
// Assumes the block answers each bus access after one wait cycle.
`timescale 1ns/100ps
module test_adc_timing_and_irq_flags;
  import adc_ctrl_pkg::*;
  logic clk = 1'b0, reset_n = 1'b0, read = 1'b0, write = 1'b0;
  logic rmwRead = 1'b0, convStart = 1'b0, scanWrite = 1'b0;
  logic prioWrite = 1'b0, compareHit = 1'b0;
  logic scanOverrun = 1'b0, prioOverrun = 1'b0;
  logic [4:0] address = 5'h00, convChannel = 5'h00, scanLevel = 5'h00;
  logic [2:0] prioLevel = 3'h0;
  logic [31:0] writedata = 32'h0, readdata, rd;
  logic [3:0] byteenable = 4'hf;
  logic waitrequest, sampling, comparing, convDone, compareFuncEn;
  logic scanIrq, prioIrq, compareIrq, overrunIrq;
  int miscompares = 0, check_count = 0;

  adc_timing_and_irq_flags dut_u (.clk(clk), .reset_n(reset_n),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .rmwRead(rmwRead), .readdata(readdata),
    .waitrequest(waitrequest), .convStart(convStart),
    .convChannel(convChannel), .scanWrite(scanWrite),
    .scanLevel(scanLevel), .prioWrite(prioWrite), .prioLevel(prioLevel),
    .compareHit(compareHit), .scanOverrun(scanOverrun),
    .prioOverrun(prioOverrun), .sampling(sampling),
    .comparing(comparing), .convDone(convDone),
    .compareFuncEn(compareFuncEn), .scanIrq(scanIrq), .prioIrq(prioIrq),
    .compareIrq(compareIrq), .overrunIrq(overrunIrq));

  // ----------------------------------------------------------------------
  // Clock, verdict and watchdog
  // ----------------------------------------------------------------------
  // The clock toggles every 50 ns for a 100 ns period.
  initial begin
    forever #50 clk = ~clk;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up

  // The whole sequence needs well under two thousand cycles.
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    wrap_up();
  end

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  // Compares a seen value with the expected one, counting both outcomes.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // One bus access; the request stands until waitrequest is seen low.
  // A hung slave is caught by the watchdog, not by a local limit.
  task automatic bus(input logic [4:0] a, input logic wr,
                     input logic [31:0] d, input logic rmw);
    address <= a;
    write <= wr;
    read <= !wr;
    writedata <= d;
    rmwRead <= rmw && !wr;
    do begin
      @(posedge clk);
    end while (waitrequest !== 1'b0);
    rd = readdata; // Whole word taken in one access.
    read <= 1'b0;
    write <= 1'b0;
    rmwRead <= 1'b0;
    @(posedge clk);
  endtask : bus

  // Pulses FIFO and comparator events for one cycle, then lets them land.
  task automatic ev(input logic s, input logic [4:0] sl, input logic p,
                    input logic [2:0] pl, input logic c);
    scanWrite <= s;
    scanLevel <= sl;
    prioWrite <= p;
    prioLevel <= pl;
    compareHit <= c;
    @(posedge clk);
    scanWrite <= 1'b0;
    prioWrite <= 1'b0;
    compareHit <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : ev

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  // Starts one conversion and measures each phase in whole cycles.
  task automatic conv(input logic [4:0] ch, input int s, input int c);
    int sc, cc, fc, dk;
    sc = 0;
    cc = 0;
    fc = 0;
    dk = 0;
    convChannel <= ch;
    convStart <= 1'b1; // Settings are programmed first.
    @(posedge clk);
    convStart <= 1'b0;
    for (int k = 1; k <= s + c + 4; k++) begin
      @(posedge clk);
      if (sampling === 1'b1) sc++;
      if (comparing === 1'b1 && fc == 0) fc = k;
      if (comparing === 1'b1) cc++;
      if (convDone === 1'b1) dk = k;
    end
    chk(sc, s);
    chk(cc, c);
    chk(fc, s + 1);
    chk(dk, s + c + 1);
  endtask : conv

  // Setting A is x1 count 4, setting B is x4 count 1, channel 3 uses B.
  task automatic timing_test;
    bus(OFS_SAMPLE_A, 1'b1, 32'h0000_0004, 1'b0);
    bus(OFS_SAMPLE_B, 1'b1, 32'h0000_0101, 1'b0);
    bus(OFS_SAMPLE_SEL, 1'b1, 32'h0000_0008, 1'b0);
    bus(OFS_COMPARE_TIME, 1'b1, 32'h0, 1'b0);
    bus(OFS_SAMPLE_B, 1'b0, 32'h0, 1'b0);
    chk(rd, 32'h0000_0101);
    conv(5'h01, 6, 28);
    conv(5'h03, 9, 28);
    bus(OFS_COMPARE_TIME, 1'b1, 32'h0000_0001, 1'b0);
    conv(5'h01, 6, 42);
    bus(OFS_STATUS, 1'b0, 32'h0, 1'b0);
    chk(rd, 32'h0);
  endtask : timing_test

  // Event flags, clearing writes, the merged read and request levels.
  task automatic flag_test;
    bus(5'h1c, 1'b0, 32'h0, 1'b0);
    chk(rd, 32'h0);
    ev(1'b0, 5'h00, 1'b0, 3'h0, 1'b1);
    bus(OFS_IRQ_CTRL, 1'b0, 32'h0, 1'b0);
    chk(rd, 32'h0);
    bus(OFS_THRESHOLD, 1'b1, 32'h0001_0102, 1'b0);
    chk(compareFuncEn, 1'b1);
    ev(1'b1, 5'h01, 1'b1, 3'h0, 1'b0);
    bus(OFS_IRQ_CTRL, 1'b0, 32'h0, 1'b0);
    chk(rd, 32'h0);
    ev(1'b1, 5'h02, 1'b1, 3'h1, 1'b1);
    bus(OFS_IRQ_CTRL, 1'b0, 32'h0, 1'b0);
    chk(rd, 32'h0000_e000);
    chk({scanIrq, prioIrq, compareIrq}, 3'h0);
    bus(OFS_IRQ_CTRL, 1'b1, 32'h0000_ff00, 1'b0);
    bus(OFS_IRQ_CTRL, 1'b0, 32'h0, 1'b0);
    chk(rd, 32'h0000_ef00);
    chk({scanIrq, prioIrq, compareIrq, overrunIrq}, 4'he);
    bus(OFS_IRQ_CTRL, 1'b1, 32'h0000_0f00, 1'b0);
    bus(OFS_IRQ_CTRL, 1'b0, 32'h0, 1'b0);
    chk(rd, 32'h0000_0f00);
    chk({scanIrq, prioIrq, compareIrq}, 3'h0);
    bus(OFS_IRQ_CTRL, 1'b0, 32'h0, 1'b1);
    chk(rd, 32'h0000_ef00);
    bus(OFS_IRQ_CTRL, 1'b0, 32'h0, 1'b0);
    chk(rd, 32'h0000_0f00);
    scanOverrun <= 1'b1;
    repeat (3) @(posedge clk);
    chk(overrunIrq, 1'b1);
    scanOverrun <= 1'b0;
    prioOverrun <= 1'b1;
    repeat (3) @(posedge clk);
    chk(overrunIrq, 1'b1);
    prioOverrun <= 1'b0;
    repeat (3) @(posedge clk);
    chk(overrunIrq, 1'b0);
  endtask : flag_test

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  // Reset is held five cycles, then each scenario runs in turn.
  initial begin
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    flag_test();
    timing_test();
    wrap_up();
  end
endmodule : test_adc_timing_and_irq_flags
